// file: src/sae_pkg.sv
// Constants, register map and types of the absolute encoder serial port
package sae_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          MONO_NS         = 20000;
    localparam int          MONO_TOL_NS     = 10000;
    localparam int          MONO_W          = 13;
    localparam logic [12:0] MONO_CYC        = 13'(MONO_NS / CLK_PERIOD_NS);
    localparam int          STARTUP_MS      = 250;
    localparam longint      STARTUP_CYC_L   = (longint'(STARTUP_MS) * 1000000) / CLK_PERIOD_NS;
    localparam int          FUNC_DELAY_MS   = 10;
    localparam int          ZERO_HOLD_MS    = 100;

    // ------------------------------------------------------------
    // Frame format
    // ------------------------------------------------------------
    localparam logic [4:0]  FRAME_BITS_RST  = 5'h19;
    localparam logic [4:0]  ST_BITS_MAX     = 5'h10;
    localparam logic [3:0]  MT_BITS_MAX     = 4'he;
    localparam logic [4:0]  ST_BITS_RST     = 5'h0c;
    localparam logic [3:0]  MT_BITS_RST     = 4'hc;
    localparam logic [5:0]  REPEAT_MAX_BITS = 6'h0d;
    localparam int          POS_W           = 30;
    localparam int          SH_W            = 32;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  REG_CTRL        = 5'h00;
    localparam logic [4:0]  REG_PRESET      = 5'h04;
    localparam logic [4:0]  REG_STATUS      = 5'h08;
    localparam logic [4:0]  REG_POS         = 5'h0c;
    localparam logic [4:0]  REG_WORD        = 5'h10;
    localparam logic [4:0]  REG_FRAMES      = 5'h14;

    // CTRL fields
    localparam int          CTRL_GRAY       = 0;
    localparam int          CTRL_SPECIAL    = 1;
    localparam int          CTRL_ST_LSB     = 2;
    localparam int          CTRL_MT_LSB     = 7;
    localparam int          CTRL_FLEN_LSB   = 11;
    localparam logic [15:0] CTRL_RST        = {FRAME_BITS_RST, MT_BITS_RST, ST_BITS_RST,
                                               1'b0, 1'b1};
    localparam logic [29:0] PRESET_RST      = 30'h0;

    // STATUS fields
    localparam int          STAT_READY      = 0;
    localparam int          STAT_BUSY       = 1;
    localparam int          STAT_MONO       = 2;
    localparam int          STAT_REPEAT     = 3;
    localparam int          STAT_DIR        = 4;
    localparam int          STAT_ZERO       = 5;
    localparam int          STAT_REP_OK     = 6;

    typedef enum logic [1:0] {
        LNK_IDLE,
        LNK_SHIFT,
        LNK_MONO
    } sae_link_e;

endpackage

// file: src/sae_sync_if.sv
// Pin group passed through the input synchroniser
`timescale 1ns/10ps
interface sae_sync_if #(
    parameter int W = 3
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport sync_mp (input raw, output sync);
    modport user_mp (output raw, input sync);
endinterface

// file: src/sae_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module sae_sync
    import sae_pkg::*;
#(
    parameter int W = 3
)(
    input  wire logic  clk,
    input  wire logic  arst_n,
    sae_sync_if.sync_mp pins
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= pins.raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign pins.sync = sync_q;
endmodule

// file: src/sae_port.sv
// Serial position port of a multiturn absolute encoder with register access
`timescale 1ns/10ps

module sae_port
    import sae_pkg::*;
#(
    parameter int STARTUP_CYC = int'(STARTUP_CYC_L)
)(
    input  wire logic        CLK_SYS,
    input  wire logic        ARST_N,
    input  wire logic        SSI_CLK,
    output logic             SSI_DATA,
    input  wire logic        DIR_SEL,
    input  wire logic        ZERO_SET,
    input  wire logic        STEP_STB,
    input  wire logic        STEP_CW,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [POS_W-1:0] to_gray(input logic [POS_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int k = 0; k < 4; k++)
        begin
            if (be[k])
            begin
                r[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sae_sync_if #(.W(3)) pins_if ();

    assign pins_if.raw = {ZERO_SET, DIR_SEL, SSI_CLK};

    sae_sync #(
        .W      (3)
    ) u_sync (
        .clk    (CLK_SYS),
        .arst_n (ARST_N),
        .pins   (pins_if.sync_mp)
    );

    wire ssi_clk_s = pins_if.sync[0];
    wire dir_s     = pins_if.sync[1];
    wire zero_s    = pins_if.sync[2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]       ctrl_q;
    logic [POS_W-1:0]  preset_q;
    logic [POS_W-1:0]  pos_q;
    logic [SH_W-1:0]   sh_q;
    logic [SH_W-1:0]   word_q;
    logic [4:0]        cnt_q;
    logic [MONO_W-1:0] timer_q;
    logic              clk_prev_q;
    logic              data_q;
    logic              repeat_q;
    logic [31:0]       frames_q;
    logic [31:0]       start_cnt_q;
    logic              ready_q;
    logic              ack_q;
    logic [31:0]       rdata_q;
    sae_link_e         state_q;

    // ------------------------------------------------------------
    // Format decode
    // ------------------------------------------------------------
    wire [4:0] st_req  = ctrl_q[CTRL_ST_LSB +: 5];
    wire [3:0] mt_req  = ctrl_q[CTRL_MT_LSB +: 4];
    wire [4:0] st_bits = (st_req > ST_BITS_MAX) ? ST_BITS_MAX : st_req;
    wire [3:0] mt_bits = (mt_req > MT_BITS_MAX) ? MT_BITS_MAX : mt_req;
    wire [5:0] n_bits  = {1'b0, st_bits} + {2'b00, mt_bits};
    wire [4:0] flen    = ctrl_q[CTRL_FLEN_LSB +: 5];
    wire       use_gray = ctrl_q[CTRL_GRAY];
    wire       special  = ctrl_q[CTRL_SPECIAL];
    wire       rep_ok   = (n_bits <= REPEAT_MAX_BITS);

    wire [31:0]      pos_mask  = ~(32'hffffffff << n_bits);
    wire [POS_W-1:0] pos_mask30 = pos_mask[POS_W-1:0];
    wire [POS_W-1:0] pos_code  = use_gray ? to_gray(pos_q) : pos_q;
    wire [5:0]       sh_pos    = 6'd32 - n_bits;
    wire [5:0]       sh_spec   = 6'd31 - n_bits;
    wire [SH_W-1:0]  pos_just  = {2'b00, pos_code & pos_mask30} << sh_pos;
    wire [SH_W-1:0]  spec_just = {31'h0, special} << sh_spec;
    wire [SH_W-1:0]  word_now  = pos_just | spec_just;

    // ------------------------------------------------------------
    // Link edge detection
    // ------------------------------------------------------------
    wire clk_fall   = clk_prev_q & ~ssi_clk_s;
    wire clk_rise   = ~clk_prev_q & ssi_clk_s;
    wire mono_done  = (timer_q == '0);
    wire last_bit   = ({27'h0, cnt_q} + 32'd1) >= {27'h0, flen};

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            clk_prev_q <= 1'b1;
        end
        else
        begin
            clk_prev_q <= ssi_clk_s;
        end
    end

    // ------------------------------------------------------------
    // Power-up delay
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            start_cnt_q <= '0;
            ready_q     <= 1'b0;
        end
        else if (!ready_q)
        begin
            start_cnt_q <= start_cnt_q + 32'd1;
            ready_q     <= (start_cnt_q + 32'd1 >= 32'(STARTUP_CYC));
        end
    end

    // ------------------------------------------------------------
    // Position counter
    // ------------------------------------------------------------
    wire count_down = STEP_CW ? dir_s : ~dir_s;

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pos_q <= '0;
        end
        else if (zero_s)
        begin
            pos_q <= preset_q & pos_mask30;
        end
        else if (STEP_STB)
        begin
            pos_q <= (count_down ? pos_q - 30'd1 : pos_q + 30'd1) & pos_mask30;
        end
    end

    // ------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q  <= LNK_IDLE;
            data_q   <= 1'b1;
            sh_q     <= '0;
            word_q   <= '0;
            cnt_q    <= '0;
            timer_q  <= '0;
            repeat_q <= 1'b0;
            frames_q <= '0;
        end
        else
        begin
            unique case (state_q)
                LNK_IDLE:
                begin
                    data_q <= 1'b1;
                    if (ready_q && clk_fall)
                    begin
                        sh_q     <= word_now;
                        word_q   <= word_now;
                        cnt_q    <= '0;
                        timer_q  <= MONO_CYC;
                        repeat_q <= 1'b0;
                        state_q  <= LNK_SHIFT;
                    end
                end
                LNK_SHIFT:
                begin
                    if (clk_rise)
                    begin
                        data_q <= sh_q[SH_W-1];
                        sh_q   <= sh_q << 1;
                        cnt_q  <= cnt_q + 5'd1;
                        if (last_bit)
                        begin
                            state_q  <= LNK_MONO;
                            frames_q <= frames_q + 32'd1;
                        end
                    end
                    if (clk_fall)
                    begin
                        timer_q <= MONO_CYC;
                    end
                    else if (mono_done)
                    begin
                        data_q  <= 1'b1;
                        state_q <= LNK_IDLE;
                    end
                    else
                    begin
                        timer_q <= timer_q - 13'd1;
                    end
                end
                LNK_MONO:
                begin
                    if (mono_done)
                    begin
                        data_q  <= 1'b1;
                        state_q <= LNK_IDLE;
                    end
                    else
                    begin
                        timer_q <= timer_q - 13'd1;
                        if (clk_fall && rep_ok)
                        begin
                            sh_q     <= word_q;
                            cnt_q    <= '0;
                            timer_q  <= MONO_CYC;
                            repeat_q <= 1'b1;
                            state_q  <= LNK_SHIFT;
                        end
                        else if (clk_rise)
                        begin
                            data_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    assign SSI_DATA = data_q;

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state per access
    // ------------------------------------------------------------
    wire req     = AVS_READ | AVS_WRITE;
    wire wr_take = AVS_WRITE & ack_q;

    wire hit_ctrl   = (AVS_ADDRESS == REG_CTRL);
    wire hit_preset = (AVS_ADDRESS == REG_PRESET);
    wire hit_status = (AVS_ADDRESS == REG_STATUS);
    wire hit_pos    = (AVS_ADDRESS == REG_POS);
    wire hit_word   = (AVS_ADDRESS == REG_WORD);
    wire hit_frames = (AVS_ADDRESS == REG_FRAMES);

    wire [31:0] status_v = {25'h0, rep_ok, zero_s, dir_s, repeat_q,
                            (state_q == LNK_MONO), (state_q != LNK_IDLE), ready_q};

    wire [31:0] rd_mux = hit_ctrl   ? {16'h0, ctrl_q}   :
                         hit_preset ? {2'h0, preset_q}  :
                         hit_status ? status_v          :
                         hit_pos    ? {2'h0, pos_q}     :
                         hit_word   ? word_q            :
                         hit_frames ? frames_q          : 32'h0;

    wire [31:0] ctrl_new   = be_merge({16'h0, ctrl_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] preset_new = be_merge({2'h0, preset_q}, AVS_WRITEDATA, AVS_BYTEENABLE);

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (AVS_READ && !ack_q)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl_q   <= CTRL_RST;
            preset_q <= PRESET_RST;
        end
        else if (wr_take)
        begin
            if (hit_ctrl)
            begin
                ctrl_q <= ctrl_new[15:0];
            end
            if (hit_preset)
            begin
                preset_q <= preset_new[POS_W-1:0];
            end
        end
    end

    assign AVS_WAITREQUEST = req & ~ack_q;
    assign AVS_READDATA    = rdata_q;

endmodule

// file: tb/sae_port_properties.sv
// Concurrent checks on the serial and bus ports of the encoder port
`timescale 1ns/10ps
module sae_port_properties
    import sae_pkg::*;
#(
    parameter int STARTUP_CYC = 100
)(
    input wire logic        CLK_SYS,
    input wire logic        ARST_N,
    input wire logic        SSI_CLK,
    input wire logic        SSI_DATA,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [4:0]  AVS_ADDRESS,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST
);
    // ------------------------------------------------------------
    // Link activity counters
    // ------------------------------------------------------------
    logic        clk_q;
    logic [12:0] idle_q;
    logic [2:0]  rise_q;
    wire logic   req     = AVS_READ | AVS_WRITE;
    wire logic   moved   = SSI_CLK != clk_q;
    wire logic   rose    = SSI_CLK & ~clk_q;

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            clk_q  <= 1'b1;
            idle_q <= 13'h0;
            rise_q <= 3'h7;
        end
        else
        begin
            clk_q  <= SSI_CLK;
            idle_q <= moved ? 13'h0 : idle_q + {12'h0, idle_q != 13'h1fff};
            rise_q <= rose ? 3'h0 : rise_q + {2'h0, rise_q != 3'h7};
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    idle_high_a: assert property (idle_q >= 13'h1004 |-> SSI_DATA)
        else $error("data not high on idle link");
    data_change_a: assert property (!$stable(SSI_DATA) |-> rise_q <= 3'h5 ||
        (idle_q >= 13'hf8c && idle_q <= 13'hfb4)) else $error("data moved off a rise");
    fall_quiet_a: assert property ($fell(SSI_CLK) |=> $stable(SSI_DATA)[*5])
        else $error("data moved on a falling clock");
    bit_width_a: assert property (!$stable(SSI_DATA) |=> $stable(SSI_DATA)[*4])
        else $error("data bit too short");
    bus_wait_a: assert property ($rose(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer not after one wait state");
    wait_bound_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus stalled too long");
    unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 5'h14
        |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
    readdata_hold_a: assert property (!AVS_READ ##1 !AVS_READ |-> $stable(AVS_READDATA))
        else $error("read data moved without a read");

    cover property ($rose(SSI_DATA) && idle_q > 13'hf00);
    cover property (AVS_WRITE && !AVS_WAITREQUEST);
    cover property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 5'h14);
endmodule

bind sae_port sae_port_properties #(.STARTUP_CYC(STARTUP_CYC)) u_props (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SSI_CLK(SSI_CLK), .SSI_DATA(SSI_DATA),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

// file: tb/sae_ssi_master.sv
// Behavioural serial controller that clocks frames out of the encoder port
`timescale 1ns/10ps
module sae_ssi_master
#(
    parameter int HALF_NS = 32
)(
    output logic      ssi_clk,
    input  wire logic ssi_data
);
    // Link clock rests high outside bursts
    initial ssi_clk = 1'b1;

    // Clocks n pulses; each bit is read half a period after its rise, MSB first
    task automatic burst(input int n, output logic [31:0] word);
        word = 32'h0;
        #3;
        for (int i = 0; i < n; i++)
        begin
            ssi_clk = 1'b0;
            #HALF_NS;
            ssi_clk = 1'b1;
            #HALF_NS;
            word = {word[30:0], ssi_data};
        end
    endtask
endmodule

// file: tb/sae_port_bench.sv
// Self-checking bench for the absolute encoder serial port
`timescale 1ns/10ps
module sae_port_bench
    import sae_pkg::*;
;
    logic        clk_sys;
    logic        arst_n;
    logic        ssi_clk;
    logic        ssi_data;
    logic        dir_sel;
    logic        zero_set;
    logic        step_stb;
    logic        step_cw;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rd;
    int          failures;
    int          total_checks;

    always #2.5 clk_sys = ~clk_sys;

    sae_port #(.STARTUP_CYC(100)) dut (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .SSI_CLK(ssi_clk), .SSI_DATA(ssi_data),
        .DIR_SEL(dir_sel), .ZERO_SET(zero_set), .STEP_STB(step_stb), .STEP_CW(step_cw),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

    sae_ssi_master master (.ssi_clk(ssi_clk), .ssi_data(ssi_data));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50)
            failures++;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd_check(input logic [4:0] a, input logic [31:0] exp);
        bus_op(1'b0, a, 32'h0);
        check_word(rd, exp);
    endtask

    task automatic frame(input int n, input logic [31:0] exp);
        logic [31:0] w;
        master.burst(n, w);
        check_word(w, exp);
        @(posedge clk_sys);
    endtask

    task automatic pause();
        repeat ((MONO_NS + MONO_TOL_NS) / CLK_PERIOD_NS + 200) @(posedge clk_sys);
    endtask

    task automatic step(input logic cw, input int k);
        repeat (k)
        begin
            step_stb <= 1'b1;
            step_cw  <= cw;
            @(posedge clk_sys);
            step_stb <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    function automatic logic [31:0] ctrl(input logic g, input logic s, input logic [4:0] st,
                                         input logic [3:0] mt, input logic [4:0] fl);
        return {16'h0, fl, mt, st, s, g};
    endfunction

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial
    begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        dir_sel = 1'b1;
        zero_set = 1'b0;
        step_stb = 1'b0;
        step_cw = 1'b1;
        avs_address = 5'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        failures = 0;
        total_checks = 0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check_word({31'h0, ssi_data}, 32'h1);
        rd_check(REG_CTRL, {16'h0, CTRL_RST});
        rd_check(REG_PRESET, 32'h0);
        bus_op(1'b1, 5'h1c, 32'hffffffff);
        rd_check(5'h1c, 32'h0);
        repeat (120) @(posedge clk_sys);
        bus_op(1'b0, REG_STATUS, 32'h0);
        check_word({31'h0, rd[STAT_READY]}, 32'h1);
        check_word({31'h0, rd[STAT_REP_OK]}, 32'h0);
        bus_op(1'b1, REG_CTRL, ctrl(1'b0, 1'b1, 5'h0c, 4'hc, 5'h19));
        bus_op(1'b1, REG_PRESET, 32'h123);
        zero_set <= 1'b1;
        repeat (20) @(posedge clk_sys);
        zero_set <= 1'b0;
        repeat (10) @(posedge clk_sys);
        frame(25, {7'h0, 24'h123, 1'b1});
        pause();
        step(1'b1, 2);
        frame(25, {7'h0, 24'h121, 1'b1});
        pause();
        dir_sel <= 1'b0;
        repeat (10) @(posedge clk_sys);
        step(1'b1, 4);
        step(1'b0, 1);
        frame(25, {7'h0, 24'h124, 1'b1});
        pause();
        bus_op(1'b1, REG_CTRL, ctrl(1'b1, 1'b0, 5'h0c, 4'hc, 5'h19));
        frame(25, {7'h0, 24'h1b6, 1'b0});
        repeat (int'(MONO_CYC) - 100) @(posedge clk_sys);
        check_word({31'h0, ssi_data}, 32'h0);
        repeat (200) @(posedge clk_sys);
        check_word({31'h0, ssi_data}, 32'h1);
        pause();
        bus_op(1'b1, REG_CTRL, ctrl(1'b0, 1'b0, 5'h08, 4'h5, 5'h0e));
        bus_op(1'b0, REG_STATUS, 32'h0);
        check_word({31'h0, rd[STAT_REP_OK]}, 32'h1);
        frame(28, {4'h0, 14'h248, 14'h248});
        bus_op(1'b0, REG_STATUS, 32'h0);
        check_word({31'h0, rd[STAT_REPEAT]}, 32'h1);
        pause();
        step(1'b1, 1);
        frame(14, {18'h0, 14'h24a});
        pause();
        rd_check(REG_FRAMES, 32'h7);
        rd_check(REG_POS, 32'h125);
        give_verdict();
    end
endmodule
